/* verilog/ecl_pkg.sv */
// constants for the reset-time configuration loader
package ecl_pkg;
  // eeprom image layout
  localparam logic [7:0] ECL_VALID_PATTERN = 8'hA5;
  localparam logic [7:0] ECL_ADDR_VALID = 8'h00;
  localparam logic [7:0] ECL_ADDR_MAC_FIRST = 8'h01;
  localparam logic [7:0] ECL_ADDR_MAC_LAST = 8'h06;
  localparam logic [7:0] ECL_ADDR_STRAP_FLAG = 8'h07;
  localparam logic [7:0] ECL_ADDR_STRAP_LAST = 8'h0B;
  localparam logic [7:0] ECL_ADDR_BURST_FLAG = 8'h0C;
  // register addresses reachable by the loader
  localparam logic [9:0] ECL_CSR_MIN_ADDR = 10'h100;
  localparam logic [9:0] ECL_PHY_DATA_ADDR = 10'h0A4;
  localparam logic [9:0] ECL_PHY_ACCESS_ADDR = 10'h0A8;
  localparam logic [9:0] ECL_HOST_ADDR_LOW = 10'h108;
  localparam logic [9:0] ECL_HOST_ADDR_HIGH = 10'h10C;
  localparam logic [9:0] ECL_FABRIC_ADDR_LOW = 10'h110;
  localparam logic [9:0] ECL_FABRIC_ADDR_HIGH = 10'h114;
  // phy register numbers and fixed bits
  localparam logic [4:0] ECL_PHY_REG_CTRL = 5'h00;
  localparam logic [4:0] ECL_PHY_REG_ADV = 5'h04;
  localparam logic [4:0] ECL_PHY_REG_MODES = 5'h12;
  localparam int ECL_CTRL_RESTART_BIT = 9;
  localparam int ECL_ACCESS_WRITE_BIT = 1;
  localparam int ECL_ACCESS_BUSY_BIT = 0;
  // strap byte field positions
  localparam int ECL_STRAP_AUTONEG = 0;
  localparam int ECL_STRAP_DUPLEX = 1;
  localparam int ECL_STRAP_SPEED = 2;
  localparam int ECL_STRAP_FDPAUSE = 6;
  localparam int ECL_STRAP_HEARTBEAT = 4;
  // reset value of strap store before any load
  localparam logic [31:0] ECL_STRAP_RESET = 32'hFF00_0707;
  // states
  typedef enum logic [7:0] {
    ECL_IDLE = 8'h01,
    ECL_READ = 8'h02,
    ECL_WAITRD = 8'h04,
    ECL_CSR = 8'h08,
    ECL_PHY = 8'h10,
    ECL_PHYWAIT = 8'h20,
    ECL_DONE = 8'h40,
    ECL_WAIT = 8'h80
  } ecl_state_t;
endpackage

/* verilog/ecl_phy_word.sv */
// builds the three synchronised phy register words from one port's straps
`timescale 1ns/1ps
module ecl_phy_word
  import ecl_pkg::*;
(
  // strap byte of the port
  input wire logic [7:0] i_strap,
  // selection 0 advert, 1 special modes, 2 basic control
  input wire logic [1:0] i_sel,
  // result
  output logic [4:0] o_reg_num,
  output logic [15:0] o_word
);
  // whole words, any bits software changed earlier are replaced (see RQ18)
  wire [15:0] adv_word = {5'h00, i_strap[ECL_STRAP_FDPAUSE], 5'h03, 5'h01};
  wire [15:0] modes_word = {8'h00, 1'b0, i_strap[ECL_STRAP_AUTONEG],
    i_strap[ECL_STRAP_SPEED], i_strap[ECL_STRAP_DUPLEX], 4'h1};
  // restart negotiation so the new advert takes effect (see RQ17)
  wire [15:0] ctrl_word = {2'b00, i_strap[ECL_STRAP_SPEED], i_strap[ECL_STRAP_AUTONEG],
    2'b00, 1'b1, i_strap[ECL_STRAP_DUPLEX], 8'h00};
  assign o_reg_num = (i_sel == 2'd0) ? ECL_PHY_REG_ADV :
    (i_sel == 2'd1) ? ECL_PHY_REG_MODES : ECL_PHY_REG_CTRL;
  assign o_word = (i_sel == 2'd0) ? adv_word : (i_sel == 2'd1) ? modes_word : ctrl_word;
endmodule

/* verilog/ecl_loader.sv */
// reset-time configuration loader: eeprom image into csrs, straps and phys
//
// Behaviour
// (RQ1) writes only csrs 100h up, plus A4/A8
// (RQ2) full run on pin, por, digital reset, rerun
// (RQ3) soft reset reloads host mac only
// (RQ4) busy set and ready cleared while active
// (RQ5) host makes no writes while not ready
// (RQ6) byte 0 not A5: sync phys, finish
// (RQ7) further bytes read in ascending order
// (RQ8) mac bytes go to host and fabric
// (RQ9) bytes 1-4 low word, 5-6 high
// (RQ10) byte 12 burst flag, 13 count; reads stop at byte 12 and the count stays 00h
// (RQ11) soft reset in wait rereads bytes 0-6
// (RQ12) soft reload leaves fabric mac untouched
// (RQ13) byte 7 A5 loads straps 8-11
// (RQ14) bad strap flag: read, discard, still sync
// (RQ15) strap byte fields as documented layout
// (RQ16) every run writes three phy regs each port; soft reloads write none
// (RQ17) basic control write restarts negotiation
// (RQ18) phy registers written as whole words
// (RQ19) no burst flag: finish, wait, clear busy
// (RQ20) ready set again on finish
`timescale 1ns/1ps
module ecl_loader
  import ecl_pkg::*;
#(
  parameter int PORTS = 2
)(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // start requests (pulses from same-clock logic)
  input wire logic i_full_start,
  input wire logic i_soft_start,
  // eeprom controller byte reads
  output logic o_ee_rd_req,
  output logic [7:0] o_ee_addr,
  input wire logic i_ee_rd_done,
  input wire logic [7:0] i_ee_rd_data,
  // register access mux writes
  output logic o_csr_wr,
  output logic [9:0] o_csr_addr,
  output logic [31:0] o_csr_data,
  input wire logic i_csr_done,
  input wire logic i_phy_busy,
  // status
  output logic o_busy,
  output logic o_ready,
  output logic o_burst_valid,
  output logic [7:0] o_burst_count,
  // strap outputs
  output logic [31:0] o_straps
);
  // ------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------
  ecl_state_t state_reg, state_next;
  logic [7:0] addr_reg;
  logic soft_reg;
  logic strap_ok_reg;
  logic [47:0] mac_reg;
  logic [31:0] strap_reg;
  logic [31:0] strap_tmp_reg;
  logic [2:0] csr_idx_reg;
  logic [2:0] phy_idx_reg;
  logic phy_phase_reg;
  logic [7:0] bcount_reg;
  logic bvalid_reg;
  logic wr_wait_reg;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire start_full = i_full_start;
  // soft reload only honoured in the wait state (see RQ11)
  wire start_soft = i_soft_start && (state_reg == ECL_WAIT) && !i_full_start;
  wire byte_valid = (i_ee_rd_data == ECL_VALID_PATTERN);
  wire last_mac = (addr_reg == ECL_ADDR_MAC_LAST);
  // soft runs stop after the mac, full runs continue to the burst flag (see RQ3)
  wire last_byte = soft_reg ? last_mac : (addr_reg == ECL_ADDR_BURST_FLAG);
  // soft reload writes only the two host words (see RQ12)
  wire [2:0] csr_last = soft_reg ? 3'd1 : 3'd3;
  wire port_sel = (phy_idx_reg >= 3'd3);
  logic [4:0] phy_reg_num;
  logic [15:0] phy_word;
  ecl_phy_word u_word (
    .i_strap(port_sel ? strap_reg[15:8] : strap_reg[7:0]),
    .i_sel(phy_idx_reg >= 3'd3 ? 2'(phy_idx_reg - 3'd3) : phy_idx_reg[1:0]),
    .o_reg_num(phy_reg_num),
    .o_word(phy_word)
  );
  wire [4:0] phy_addr = port_sel ? 5'd2 : 5'd1;
  // host words at 108/10C, fabric words at 110/114, all above 100h (see RQ1)
  wire [9:0] csr_addr_sel = (csr_idx_reg == 3'd0) ? ECL_HOST_ADDR_LOW :
    (csr_idx_reg == 3'd1) ? ECL_HOST_ADDR_HIGH :
    (csr_idx_reg == 3'd2) ? ECL_FABRIC_ADDR_LOW : ECL_FABRIC_ADDR_HIGH;
  // byte 1 lands in bits 7:0 of the low word (see RQ9)
  wire [31:0] csr_data_sel = csr_idx_reg[0] ? {16'h0000, mac_reg[47:32]} : mac_reg[31:0];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ECL_IDLE: state_next = ECL_READ;
      ECL_READ: state_next = ECL_WAITRD;
      ECL_WAITRD: begin
        if (i_ee_rd_done) begin
          if (addr_reg == ECL_ADDR_VALID && !byte_valid) begin
            state_next = soft_reg ? ECL_DONE : ECL_PHY; // see RQ6
          end else if (last_byte) begin
            state_next = ECL_CSR;
          end else begin
            state_next = ECL_READ; // see RQ7
          end
        end
      end
      ECL_CSR: begin
        if (i_csr_done && csr_idx_reg == csr_last) begin
          state_next = soft_reg ? ECL_DONE : ECL_PHY;
        end
      end
      ECL_PHY: begin
        // stall here while the phy management port is busy, else no write is issued
        if (!i_phy_busy) begin
          state_next = ECL_PHYWAIT;
        end
      end
      ECL_PHYWAIT: begin
        if (i_csr_done && phy_phase_reg && phy_idx_reg == 3'(3 * PORTS - 1)) begin
          state_next = ECL_DONE;
        end else if (i_csr_done) begin
          state_next = ECL_PHY;
        end
      end
      ECL_DONE: state_next = ECL_WAIT;
      ECL_WAIT: state_next = ECL_WAIT;
      default: state_next = ECL_IDLE;
    endcase
    // full run restarts from any state (see RQ2)
    if (start_full) begin
      state_next = ECL_READ;
    end else if (start_soft) begin
      state_next = ECL_READ;
    end
  end

  // ------------------------------------------------------------
  // sequencing registers
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ECL_IDLE;
      soft_reg <= 1'b0;
      addr_reg <= ECL_ADDR_VALID;
    end else begin
      state_reg <= state_next;
      if (start_full || start_soft) begin
        soft_reg <= start_soft; // see RQ3
        addr_reg <= ECL_ADDR_VALID;
      end else if (state_reg == ECL_WAITRD && i_ee_rd_done && !last_byte) begin
        addr_reg <= addr_reg + 8'h01; // see RQ7
      end
    end
  end

  // ------------------------------------------------------------
  // captured image data
  // ------------------------------------------------------------
  wire rd_hit = (state_reg == ECL_WAITRD) && i_ee_rd_done;
  wire [2:0] mac_slot = 3'(addr_reg - ECL_ADDR_MAC_FIRST);
  wire [1:0] strap_slot = 2'(addr_reg - 8'h08);
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mac_reg <= 48'h0;
      strap_ok_reg <= 1'b0;
      strap_tmp_reg <= 32'h0;
      bvalid_reg <= 1'b0;
      bcount_reg <= 8'h00;
    end else if (rd_hit) begin
      if (addr_reg >= ECL_ADDR_MAC_FIRST && addr_reg <= ECL_ADDR_MAC_LAST) begin
        mac_reg[8 * mac_slot +: 8] <= i_ee_rd_data; // see RQ9
      end
      if (addr_reg == ECL_ADDR_STRAP_FLAG) begin
        strap_ok_reg <= byte_valid; // see RQ13
      end
      if (addr_reg > ECL_ADDR_STRAP_FLAG && addr_reg <= ECL_ADDR_STRAP_LAST) begin
        strap_tmp_reg[8 * strap_slot +: 8] <= i_ee_rd_data; // see RQ14
      end
      if (addr_reg == ECL_ADDR_BURST_FLAG) begin
        bvalid_reg <= byte_valid; // see RQ10
        bcount_reg <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // strap store, written only when the strap flag was valid
  // ------------------------------------------------------------
  wire strap_commit = (state_reg == ECL_CSR) && !soft_reg && strap_ok_reg
    && csr_idx_reg == 3'd0;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_reg <= ECL_STRAP_RESET;
    end else if (strap_commit) begin
      strap_reg <= strap_tmp_reg; // see RQ13 RQ15
    end
  end

  // ------------------------------------------------------------
  // write counters
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      csr_idx_reg <= 3'd0;
      phy_idx_reg <= 3'd0;
      phy_phase_reg <= 1'b0;
    end else if (start_full || start_soft) begin
      csr_idx_reg <= 3'd0;
      phy_idx_reg <= 3'd0;
      phy_phase_reg <= 1'b0;
    end else begin
      if (state_reg == ECL_CSR && i_csr_done) begin
        csr_idx_reg <= csr_idx_reg + 3'd1;
      end
      // data word then access word per phy register (see RQ16)
      if (state_reg == ECL_PHYWAIT && i_csr_done) begin
        phy_phase_reg <= !phy_phase_reg;
        if (phy_phase_reg) begin
          phy_idx_reg <= phy_idx_reg + 3'd1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // outputs, all registered
  // ------------------------------------------------------------
  // wait for the phy management port to idle before touching it
  wire phy_go = (state_reg == ECL_PHY) && !i_phy_busy;
  // one write in flight; a strobe before the done would repeat the same word
  wire csr_go = (state_reg == ECL_CSR) && !wr_wait_reg;
  wire [31:0] access_word = {16'h0000, phy_addr, phy_reg_num, 4'h0,
    1'b1, 1'b0} | (32'h1 << ECL_ACCESS_WRITE_BIT);
  // write outstanding from strobe until the mux answers with done (see RQ16)
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_wait_reg <= 1'b0;
    end else begin
      wr_wait_reg <= (wr_wait_reg || csr_go || phy_go) && !i_csr_done;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ee_rd_req <= 1'b0;
      o_ee_addr <= 8'h00;
      o_csr_wr <= 1'b0;
      o_csr_addr <= 10'h000;
      o_csr_data <= 32'h0;
      o_busy <= 1'b0;
      o_ready <= 1'b0;
      o_burst_valid <= 1'b0;
      o_burst_count <= 8'h00;
      o_straps <= ECL_STRAP_RESET;
    end else begin
      o_ee_rd_req <= (state_reg == ECL_READ);
      o_ee_addr <= addr_reg;
      o_csr_wr <= csr_go || (phy_go && !o_csr_wr);
      if (csr_go) begin
        o_csr_addr <= csr_addr_sel; // see RQ8 RQ1
        o_csr_data <= csr_data_sel;
      end else if (phy_go) begin
        o_csr_addr <= phy_phase_reg ? ECL_PHY_ACCESS_ADDR : ECL_PHY_DATA_ADDR; // see RQ1
        o_csr_data <= phy_phase_reg ? access_word : {16'h0000, phy_word}; // see RQ18
      end
      // busy from start until done; ready is its inverse except in reset, where both are low (see RQ4 RQ19 RQ20)
      o_busy <= (state_next != ECL_WAIT);
      o_ready <= (state_next == ECL_WAIT);
      o_burst_valid <= bvalid_reg;
      o_burst_count <= bcount_reg;
      o_straps <= strap_reg;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  busy_ready_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see RQ4
    $past(i_rst_n) |-> o_busy != o_ready) else $error("busy and ready agree");
  wr_single_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see RQ16
    (wr_wait_reg && !i_csr_done) |=> !o_csr_wr) else $error("write strobe before done");
  csr_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see RQ1
    o_csr_wr |-> (o_csr_addr >= ECL_CSR_MIN_ADDR || o_csr_addr == ECL_PHY_DATA_ADDR
      || o_csr_addr == ECL_PHY_ACCESS_ADDR)) else $error("write outside window");
  start_busy_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see RQ2
    i_full_start |=> o_busy) else $error("start did not raise busy");
  soft_fabric_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see RQ12
    (o_csr_wr && soft_reg) |-> o_csr_addr < ECL_FABRIC_ADDR_LOW)
    else $error("fabric written by soft reload");
  rd_order_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see RQ7
    (rd_hit && !last_byte && !start_full && !start_soft) |=> addr_reg == $past(addr_reg) + 8'h01)
    else $error("eeprom address not ascending");
  restart_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see RQ17
    (o_csr_wr && o_csr_addr == ECL_PHY_DATA_ADDR && $past(phy_reg_num) == ECL_PHY_REG_CTRL)
    |-> o_csr_data[ECL_CTRL_RESTART_BIT]) else $error("restart bit missing");
  invalid_done_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see RQ6
    (rd_hit && addr_reg == ECL_ADDR_VALID && !byte_valid && !soft_reg && !start_full)
    |=> state_reg == ECL_PHY) else $error("bad flag did not go to phy sync");
  strap_keep_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see RQ14
    (!strap_ok_reg && !start_full) |=> $stable(o_straps)) else $error("straps changed");
  full_run_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    state_reg == ECL_PHYWAIT ##1 state_reg == ECL_DONE);
  soft_run_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) start_soft);
  strap_load_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) strap_commit);
  phy_stall_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    state_reg == ECL_PHY && i_phy_busy);
endmodule

/* testbench/ecl_peer_model.sv */
// partner model: eeprom controller and register access mux seen by the loader
`timescale 1ns/1ps
module ecl_peer_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // eeprom controller side
  input wire logic i_ee_rd_req,
  input wire logic [7:0] i_ee_addr,
  output logic o_ee_rd_done,
  output logic [7:0] o_ee_rd_data,
  // register mux side
  input wire logic i_csr_wr,
  input wire logic [9:0] i_csr_addr,
  input wire logic [31:0] i_csr_data,
  output logic o_csr_done,
  output logic o_phy_busy
);
  logic [7:0] img [0:15];
  int dly = 0;
  int ee_cnt;
  int cs_cnt;
  int pb_cnt;
  logic ee_pend;
  logic cs_pend;
  logic [7:0] ee_a;
  logic [7:0] rd_q [$];
  logic [9:0] wa_q [$];
  logic [31:0] wd_q [$];
  // busy for 2 * dly cycles after each access write, so phy writes must really wait
  assign o_phy_busy = (pb_cnt != 0);
  // answers dly + 1 cycles after each request; data line scrambles while not valid
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ee_pend <= 1'b0;
      cs_pend <= 1'b0;
      pb_cnt <= 0;
      o_ee_rd_done <= 1'b0;
      o_csr_done <= 1'b0;
      o_ee_rd_data <= 8'h00;
    end else begin
      o_ee_rd_done <= 1'b0;
      o_csr_done <= 1'b0;
      o_ee_rd_data <= ~o_ee_rd_data;
      if (pb_cnt != 0) pb_cnt <= pb_cnt - 1;
      if (i_ee_rd_req) begin
        rd_q.push_back(i_ee_addr);
        ee_a <= i_ee_addr;
        ee_cnt <= dly;
        ee_pend <= 1'b1;
      end else if (ee_pend && ee_cnt == 0) begin
        o_ee_rd_done <= 1'b1;
        o_ee_rd_data <= img[ee_a[3:0]];
        ee_pend <= 1'b0;
      end else if (ee_pend) ee_cnt <= ee_cnt - 1;
      if (i_csr_wr) begin
        wa_q.push_back(i_csr_addr);
        wd_q.push_back(i_csr_data);
        cs_cnt <= dly;
        cs_pend <= 1'b1;
        if (i_csr_addr == 10'h0A8) pb_cnt <= 2 * dly;
      end else if (cs_pend && cs_cnt == 0) begin
        o_csr_done <= 1'b1;
        cs_pend <= 1'b0;
      end else if (cs_pend) cs_cnt <= cs_cnt - 1;
    end
  end
endmodule

/* testbench/testbench.sv */
// self-checking bench for the configuration loader
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
  import ecl_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_full_start = 1'b0;
  logic i_soft_start = 1'b0;
  logic o_ee_rd_req, i_ee_rd_done, o_csr_wr, i_csr_done, i_phy_busy;
  logic o_busy, o_ready, o_burst_valid;
  logic [7:0] o_ee_addr, i_ee_rd_data, o_burst_count;
  logic [9:0] o_csr_addr;
  logic [31:0] o_csr_data, o_straps;
  int mismatches = 0;
  int comparisons = 0;
  int idle_wr = 0;
  ecl_loader #(.PORTS(2)) u_ecl_loader (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_full_start(i_full_start), .i_soft_start(i_soft_start), .o_ee_rd_req(o_ee_rd_req),
    .o_ee_addr(o_ee_addr), .i_ee_rd_done(i_ee_rd_done), .i_ee_rd_data(i_ee_rd_data),
    .o_csr_wr(o_csr_wr), .o_csr_addr(o_csr_addr), .o_csr_data(o_csr_data),
    .i_csr_done(i_csr_done), .i_phy_busy(i_phy_busy), .o_busy(o_busy), .o_ready(o_ready),
    .o_burst_valid(o_burst_valid), .o_burst_count(o_burst_count), .o_straps(o_straps));
  ecl_peer_model u_peer (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_ee_rd_req(o_ee_rd_req), .i_ee_addr(o_ee_addr), .o_ee_rd_done(i_ee_rd_done),
    .o_ee_rd_data(i_ee_rd_data), .i_csr_wr(o_csr_wr), .i_csr_addr(o_csr_addr),
    .i_csr_data(o_csr_data), .o_csr_done(i_csr_done), .o_phy_busy(i_phy_busy));
  // ----------------------------------------
  // clock and watchers
  // ----------------------------------------
  initial begin
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // a write while not busy would hit a host that believes it owns the bus
  always @(posedge i_sys_clk) if (o_csr_wr === 1'b1 && o_busy !== 1'b1) idle_wr++;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    `CHK(idle_wr, 0)
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // image: byte i = base + i, with the three flag bytes given
  task automatic load_image(input logic [7:0] v0, s7, b12, base);
    for (int i = 0; i < 16; i++) u_peer.img[i] = base + 8'(i);
    u_peer.img[0] = v0;
    u_peer.img[7] = s7;
    u_peer.img[12] = b12;
    u_peer.rd_q.delete();
    u_peer.wa_q.delete();
    u_peer.wd_q.delete();
  endtask
  // bounded waits: busy must rise, then fall, with ready its inverse
  task automatic wait_run();
    int n;
    n = 0;
    while (o_busy !== 1'b1 && n < 8) begin
      @(negedge i_sys_clk);
      n++;
    end
    `CHK(o_busy, 1'b1)
    `CHK(o_ready, 1'b0)
    n = 0;
    while (o_busy !== 1'b0 && n < 20000) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n >= 20000) begin
      mismatches++;
      stop_test();
    end else begin
      `CHK(o_ready, 1'b1)
    end
  endtask
  task automatic start(input bit full);
    @(posedge i_sys_clk);
    if (full) i_full_start <= 1'b1;
    else i_soft_start <= 1'b1;
    @(posedge i_sys_clk);
    i_full_start <= 1'b0;
    i_soft_start <= 1'b0;
    wait_run(); // no host write is issued while busy
  endtask
  task automatic chk_counts(input int nr, nw);
    `CHK(u_peer.rd_q.size(), nr)
    for (int i = 0; i < nr; i++) `CHK(u_peer.rd_q[i], 8'(i))
    `CHK(u_peer.wa_q.size(), nw)
  endtask
  task automatic chk_mac(input int k, input bit fab, input logic [7:0] b);
    `CHK(u_peer.wa_q[k], ECL_HOST_ADDR_LOW)
    `CHK(u_peer.wd_q[k], {b + 8'h04, b + 8'h03, b + 8'h02, b + 8'h01})
    `CHK(u_peer.wa_q[k + 1], ECL_HOST_ADDR_HIGH)
    `CHK(u_peer.wd_q[k + 1][15:0], {b + 8'h06, b + 8'h05})
    if (fab) begin
      `CHK(u_peer.wa_q[k + 2], ECL_FABRIC_ADDR_LOW)
      `CHK(u_peer.wd_q[k + 2], {b + 8'h04, b + 8'h03, b + 8'h02, b + 8'h01})
      `CHK(u_peer.wa_q[k + 3], ECL_FABRIC_ADDR_HIGH)
      `CHK(u_peer.wd_q[k + 3][15:0], {b + 8'h06, b + 8'h05})
    end
  endtask
  // per port: advert, special modes, control, each data then access word
  task automatic chk_phy(input int k);
    int x;
    logic [4:0] r;
    for (int p = 1; p <= 2; p++) begin
      for (int j = 0; j < 3; j++) begin
        x = k + ((p - 1) * 3 + j) * 2;
        r = (j == 0) ? ECL_PHY_REG_ADV : (j == 1) ? ECL_PHY_REG_MODES : ECL_PHY_REG_CTRL;
        `CHK(u_peer.wa_q[x], ECL_PHY_DATA_ADDR)
        `CHK(u_peer.wa_q[x + 1], ECL_PHY_ACCESS_ADDR)
        `CHK(u_peer.wd_q[x + 1][15:11], 5'(p))
        `CHK(u_peer.wd_q[x + 1][10:6], r)
        `CHK(u_peer.wd_q[x + 1][ECL_ACCESS_WRITE_BIT], 1'b1)
        if (j == 2) `CHK(u_peer.wd_q[x][ECL_CTRL_RESTART_BIT], 1'b1)
      end
    end
  endtask
  task automatic chk_full(input logic [7:0] b, input logic [31:0] st, input logic bv);
    chk_counts(13, 16);
    chk_mac(0, 1'b1, b);
    chk_phy(4);
    `CHK(o_straps, st)
    `CHK(o_burst_valid, bv)
    `CHK(o_burst_count, 8'h00)
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_run();
    load_image(8'hA5, 8'hA5, 8'hA5, 8'h10);
    repeat (12) @(posedge i_sys_clk);
    `CHK(o_busy, 1'b0)
    `CHK(o_straps, ECL_STRAP_RESET)
    i_rst_n <= 1'b1;
    wait_run();
    chk_full(8'h10, 32'h1B1A_1918, 1'b1);
  endtask
  // slow partner, strap and burst flags bad: straps kept, mac still loaded
  task automatic t_bad_straps();
    load_image(8'hA5, 8'h00, 8'h00, 8'h40);
    u_peer.dly = 3;
    start(1'b1);
    chk_full(8'h40, 32'h1B1A_1918, 1'b0);
    u_peer.dly = 0;
  endtask
  task automatic t_bad_valid();
    load_image(8'h5A, 8'hA5, 8'hA5, 8'h70);
    start(1'b1);
    chk_counts(1, 12);
    chk_phy(0);
  endtask
  // soft reset: host mac only, fabric and straps untouched
  task automatic t_soft();
    load_image(8'hA5, 8'hA5, 8'hA5, 8'h20);
    start(1'b0);
    chk_counts(7, 2);
    chk_mac(0, 1'b0, 8'h20);
    `CHK(o_straps, 32'h1B1A_1918)
    load_image(8'h00, 8'hA5, 8'hA5, 8'h30);
    start(1'b0);
    chk_counts(1, 0);
  endtask
  initial begin
    t_reset_run();
    t_bad_straps();
    t_bad_valid();
    t_soft();
    stop_test();
  end
endmodule
